// >>> dect_pkg.sv
package dect_pkg;

    // ==========================================================
    // Timing
    localparam int DECT_CLK_PERIOD_NS = 10;
    localparam int DECT_TICK_PERIOD_NS = 1000;
    localparam int DECT_TICK_CYCLES = DECT_TICK_PERIOD_NS / DECT_CLK_PERIOD_NS;
    localparam logic [6:0] DECT_TICK_LAST = 7'(DECT_TICK_CYCLES - 1);

    // ==========================================================
    // Register map, byte addresses
    localparam logic [5:0] DECT_OFS_PICK = 6'h00;
    localparam logic [5:0] DECT_OFS_INC_SRC = 6'h04;
    localparam logic [5:0] DECT_OFS_INC_MODE = 6'h08;
    localparam logic [5:0] DECT_OFS_DELAY = 6'h0C;
    localparam logic [5:0] DECT_OFS_DURATION = 6'h10;
    localparam logic [5:0] DECT_OFS_START_SRC = 6'h14;
    localparam logic [5:0] DECT_OFS_START_MODE = 6'h18;
    localparam logic [5:0] DECT_OFS_CLR_SRC = 6'h1C;
    localparam logic [5:0] DECT_OFS_CLR_MODE = 6'h20;
    localparam logic [5:0] DECT_OFS_LIVE = 6'h24;
    localparam logic [5:0] DECT_OFS_STATE = 6'h28;
    localparam logic [5:0] DECT_OFS_CAPTURED = 6'h2C;
    localparam logic [5:0] DECT_OFS_IRQ_STATUS = 6'h30;
    localparam logic [5:0] DECT_OFS_IRQ_MASK = 6'h34;

    // Interrupt layout: bit 0/1 start of counter 0/1, bit 2/3 end of counter 0/1
    localparam int DECT_IRQ_START_LSB = 0;
    localparam int DECT_IRQ_END_LSB = 2;

    // Reset values
    localparam logic [31:0] DECT_RST_WORD = 32'h0000_0000;
    localparam logic [3:0] DECT_RST_IRQ = 4'h0;
    localparam int DECT_NUM_SRC = 19;

    // ==========================================================
    // Enumerations
    typedef enum logic [4:0] {
        DECT_SRC_OFF = 5'h00, DECT_SRC_TICK = 5'h01,
        DECT_SRC_LINE0 = 5'h02, DECT_SRC_LINE1 = 5'h03, DECT_SRC_LINE2 = 5'h04, DECT_SRC_LINE3 = 5'h05,
        DECT_SRC_USER0 = 5'h06, DECT_SRC_USER1 = 5'h07, DECT_SRC_USER2 = 5'h08, DECT_SRC_USER3 = 5'h09,
        DECT_SRC_C0_START = 5'h0A, DECT_SRC_C1_START = 5'h0B, DECT_SRC_C0_END = 5'h0C, DECT_SRC_C1_END = 5'h0D,
        DECT_SRC_LB0 = 5'h0E, DECT_SRC_LB1 = 5'h0F,
        DECT_SRC_EXP_START = 5'h10, DECT_SRC_EXP_END = 5'h11, DECT_SRC_FTW = 5'h12
    } dect_src_t;

    typedef enum logic [2:0] {
        DECT_ACT_LEVEL_LOW = 3'h0, DECT_ACT_LEVEL_HIGH = 3'h1, DECT_ACT_FALLING = 3'h2,
        DECT_ACT_RISING = 3'h3, DECT_ACT_ANY_EDGE = 3'h4
    } dect_act_t;

    // Gray along idle, wait, active, completed, overflow
    typedef enum logic [2:0] {
        DECT_ST_IDLE = 3'h0, DECT_ST_WAIT = 3'h1, DECT_ST_ACTIVE = 3'h3,
        DECT_ST_COMPLETED = 3'h2, DECT_ST_OVERFLOW = 3'h6
    } dect_state_e_t;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
    } dect_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } dect_avs_rsp_t;

    typedef struct packed {
        logic [4:0] inc_src;
        logic [2:0] inc_mode;
        logic [4:0] start_src;
        logic [2:0] start_mode;
        logic [4:0] clr_src;
        logic [2:0] clr_mode;
        logic [31:0] delay;
        logic [31:0] duration;
    } dect_cfg_t;

    typedef struct packed {
        logic [31:0] count;
        logic [31:0] captured;
        dect_state_e_t status;
    } dect_run_t;

    typedef struct packed {
        dect_avs_rsp_t rsp;
        logic pick;
        dect_cfg_t [1:0] cfg;
        dect_run_t [1:0] run;
        logic [1:0] start_evt;
        logic [1:0] end_evt;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic irq;
        logic [3:0] line_s1;
        logic [3:0] line_s2;
        logic [6:0] tick_cnt;
        logic tick;
    } dect_top_state_t;

    // Sources that are already one-cycle pulses; activation mode does not apply
    function automatic logic dect_src_is_pulse(input logic [4:0] sel);
        dect_src_is_pulse = (sel == DECT_SRC_OFF) || (sel == DECT_SRC_TICK) ||
                            (sel >= DECT_SRC_C0_START && sel <= DECT_SRC_C1_END) ||
                            (sel == DECT_SRC_EXP_START) || (sel == DECT_SRC_EXP_END);
    endfunction : dect_src_is_pulse

endpackage : dect_pkg

// >>> dect_qual.sv
`timescale 1ns/1ps
module dect_qual (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Source
    input wire logic level_in,
    input wire logic pulse_in,
    input wire logic [2:0] mode_in,
    // Qualified firing
    output logic fire_out
);
    import dect_pkg::*;

    typedef struct packed {
        logic prev;
    } dect_qual_state_t;

    dect_qual_state_t st;
    dect_qual_state_t nx;

    always_comb begin
        nx = st;
        nx.prev = level_in;
        fire_out = 1'b0;
        if (pulse_in) begin
            fire_out = level_in;
        end else begin
            case (mode_in)
                DECT_ACT_LEVEL_LOW: fire_out = !level_in;
                DECT_ACT_LEVEL_HIGH: fire_out = level_in;
                DECT_ACT_FALLING: fire_out = st.prev && !level_in;
                DECT_ACT_RISING: fire_out = !st.prev && level_in;
                DECT_ACT_ANY_EDGE: fire_out = st.prev != level_in;
                default: fire_out = 1'b0;
            endcase
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st <= '0;
        end else begin
            st <= nx;
        end
    end

endmodule : dect_qual

// >>> dect_top.sv
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module dect_top (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire dect_pkg::dect_avs_req_t avs_in,
    output dect_pkg::dect_avs_rsp_t avs_out,
    // Line pins, asynchronous
    input wire logic [3:0] line_in,
    // Camera signals, same clock
    input wire logic [3:0] user_output_in,
    input wire logic [1:0] logic_block_in,
    input wire logic exposure_start_in,
    input wire logic exposure_end_in,
    input wire logic frame_trigger_wait_in,
    // Counter events
    output logic [1:0] counter_start_out,
    output logic [1:0] counter_end_out,
    // Interrupt
    output logic irq_out
);
    import dect_pkg::*;

    dect_top_state_t st;
    dect_top_state_t nx;

    logic [DECT_NUM_SRC-1:0] src_vec;
    logic [1:0][2:0][4:0] q_sel;
    logic [1:0][2:0][2:0] q_mode;
    logic [1:0][2:0] q_fire;
    logic bus_req;
    logic bus_wr;
    logic [31:0] rd_mux;
    logic [31:0] count_inc;
    logic [3:0] irq_set;
    logic [3:0] irq_clr;

    // ==========================================================
    // Source selection
    function automatic logic src_level(input logic [DECT_NUM_SRC-1:0] vec, input logic [4:0] sel);
        src_level = 1'b0;
        if (int'(sel) < DECT_NUM_SRC) begin
            src_level = vec[sel];
        end
    endfunction : src_level

    // Events come from registers, so either counter may feed the other without a loop
    assign src_vec = {frame_trigger_wait_in, exposure_end_in, exposure_start_in, logic_block_in,
                      st.end_evt, st.start_evt, user_output_in, st.line_s2, st.tick, 1'b0};

    // ==========================================================
    // Activation qualifiers: increment, start, clear per counter
    for (genvar g = 0; g < 2; g++) begin : g_cnt
        assign q_sel[g] = {st.cfg[g].clr_src, st.cfg[g].start_src, st.cfg[g].inc_src};
        assign q_mode[g] = {st.cfg[g].clr_mode, st.cfg[g].start_mode, st.cfg[g].inc_mode};
        for (genvar k = 0; k < 3; k++) begin : g_use
            dect_qual u_qual (
                .mclk_in(mclk_in),
                .rst_in(rst_in),
                .level_in(src_level(src_vec, q_sel[g][k])),
                // Codes past the last source never fire, whatever the mode
                .pulse_in(dect_src_is_pulse(q_sel[g][k]) || (int'(q_sel[g][k]) >= DECT_NUM_SRC)),
                .mode_in(q_mode[g][k]),
                .fire_out(q_fire[g][k])
            );
        end
    end

    // ==========================================================
    // Register read mux, selected counter only
    always_comb begin
        rd_mux = DECT_RST_WORD;
        case (avs_in.address & 6'h3C)
            DECT_OFS_PICK: rd_mux = {31'h0000_0000, st.pick};
            DECT_OFS_INC_SRC: rd_mux = {27'h000_0000, st.cfg[st.pick].inc_src};
            DECT_OFS_INC_MODE: rd_mux = {29'h000_0000, st.cfg[st.pick].inc_mode};
            DECT_OFS_DELAY: rd_mux = st.cfg[st.pick].delay;
            DECT_OFS_DURATION: rd_mux = st.cfg[st.pick].duration;
            DECT_OFS_START_SRC: rd_mux = {27'h000_0000, st.cfg[st.pick].start_src};
            DECT_OFS_START_MODE: rd_mux = {29'h000_0000, st.cfg[st.pick].start_mode};
            DECT_OFS_CLR_SRC: rd_mux = {27'h000_0000, st.cfg[st.pick].clr_src};
            DECT_OFS_CLR_MODE: rd_mux = {29'h000_0000, st.cfg[st.pick].clr_mode};
            DECT_OFS_LIVE: rd_mux = st.run[st.pick].count;
            DECT_OFS_STATE: rd_mux = {29'h000_0000, st.run[st.pick].status};
            DECT_OFS_CAPTURED: rd_mux = st.run[st.pick].captured;
            DECT_OFS_IRQ_STATUS: rd_mux = {28'h000_0000, st.irq_status};
            DECT_OFS_IRQ_MASK: rd_mux = {28'h000_0000, st.irq_mask};
            default: rd_mux = DECT_RST_WORD;
        endcase
    end

    assign bus_req = avs_in.read || avs_in.write;
    // A write lands only on the edge where waitrequest is seen low
    assign bus_wr = avs_in.write && !st.rsp.waitrequest;

    // ==========================================================
    // Next state
    always_comb begin
        nx = st;
        count_inc = 32'h0000_0000;
        nx.start_evt = 2'h0;
        nx.end_evt = 2'h0;

        // Line pins pass two flip-flops before use
        nx.line_s1 = line_in;
        nx.line_s2 = st.line_s1;

        // Microsecond tick
        nx.tick = 1'b0;
        if (st.tick_cnt == DECT_TICK_LAST) begin
            nx.tick_cnt = 7'h00;
            nx.tick = 1'b1;
        end else begin
            nx.tick_cnt = st.tick_cnt + 7'h01;
        end

        // Counter sequencing
        for (int i = 0; i < 2; i++) begin
            count_inc = st.run[i].count + 32'h0000_0001;
            unique case (st.run[i].status)
                DECT_ST_IDLE: begin
                    if (st.cfg[i].inc_src != DECT_SRC_OFF) begin
                        nx.run[i].count = 32'h0000_0000;
                        nx.run[i].status = (st.cfg[i].start_src == DECT_SRC_OFF) ? DECT_ST_ACTIVE : DECT_ST_WAIT;
                    end
                end
                DECT_ST_WAIT: begin
                    if (q_fire[i][1]) begin
                        nx.run[i].count = 32'h0000_0000;
                        nx.run[i].status = DECT_ST_ACTIVE;
                    end
                end
                DECT_ST_ACTIVE: begin
                    if (q_fire[i][0]) begin
                        nx.run[i].count = count_inc;
                        if (count_inc == 32'h0000_0000) begin
                            nx.run[i].status = DECT_ST_OVERFLOW;
                        end else begin
                            if (count_inc == st.cfg[i].delay) begin
                                nx.start_evt[i] = 1'b1;
                            end
                            if (count_inc == st.cfg[i].duration) begin
                                nx.end_evt[i] = 1'b1;
                                nx.run[i].status = DECT_ST_COMPLETED;
                            end
                        end
                    end
                end
                DECT_ST_COMPLETED, DECT_ST_OVERFLOW: begin
                    // A new start rearms a finished counter
                    if (q_fire[i][1]) begin
                        nx.run[i].count = 32'h0000_0000;
                        nx.run[i].status = DECT_ST_ACTIVE;
                    end
                end
                default: nx.run[i].status = DECT_ST_IDLE;
            endcase

            // Clear beats start and increment in the same cycle
            if (q_fire[i][2] && st.run[i].status != DECT_ST_IDLE) begin
                nx.run[i].captured = st.run[i].count;
                nx.run[i].count = 32'h0000_0000;
                nx.start_evt[i] = 1'b0;
                nx.end_evt[i] = 1'b0;
                nx.run[i].status = (st.cfg[i].start_src == DECT_SRC_OFF) ? DECT_ST_ACTIVE : DECT_ST_WAIT;
            end
            if (st.cfg[i].inc_src == DECT_SRC_OFF) begin
                nx.run[i].status = DECT_ST_IDLE;
            end
        end

        // Bus: one wait cycle, then answer
        if (bus_req && st.rsp.waitrequest) begin
            nx.rsp.waitrequest = 1'b0;
            nx.rsp.readdata = avs_in.read ? rd_mux : DECT_RST_WORD;
        end else begin
            nx.rsp.waitrequest = 1'b1;
        end

        irq_clr = 4'h0;
        if (bus_wr) begin
            unique case (avs_in.address & 6'h3C)
                DECT_OFS_PICK: nx.pick = avs_in.writedata[0];
                DECT_OFS_INC_SRC: nx.cfg[st.pick].inc_src = avs_in.writedata[4:0];
                DECT_OFS_INC_MODE: nx.cfg[st.pick].inc_mode = avs_in.writedata[2:0];
                DECT_OFS_DELAY: nx.cfg[st.pick].delay = avs_in.writedata;
                DECT_OFS_DURATION: nx.cfg[st.pick].duration = avs_in.writedata;
                DECT_OFS_START_SRC: begin
                    nx.cfg[st.pick].start_src = avs_in.writedata[4:0];
                    if (avs_in.writedata[4:0] != DECT_SRC_OFF) begin
                        nx.cfg[st.pick].clr_src = DECT_SRC_OFF;
                    end
                end
                DECT_OFS_START_MODE: nx.cfg[st.pick].start_mode = avs_in.writedata[2:0];
                DECT_OFS_CLR_SRC: begin
                    nx.cfg[st.pick].clr_src = avs_in.writedata[4:0];
                    if (avs_in.writedata[4:0] != DECT_SRC_OFF) begin
                        nx.cfg[st.pick].start_src = DECT_SRC_OFF;
                    end
                end
                DECT_OFS_CLR_MODE: nx.cfg[st.pick].clr_mode = avs_in.writedata[2:0];
                DECT_OFS_CAPTURED: begin
                    // Hardware capture in the same cycle overrides a software write
                    if (!q_fire[st.pick][2] || st.run[st.pick].status == DECT_ST_IDLE) begin
                        nx.run[st.pick].captured = avs_in.writedata;
                    end
                end
                DECT_OFS_IRQ_STATUS: irq_clr = avs_in.writedata[3:0];
                DECT_OFS_IRQ_MASK: nx.irq_mask = avs_in.writedata[3:0];
                default: nx.irq_mask = st.irq_mask;
            endcase
        end

        // Sticky status; a new event wins over a clear in the same cycle
        irq_set = 4'h0;
        irq_set[DECT_IRQ_START_LSB +: 2] = nx.start_evt;
        irq_set[DECT_IRQ_END_LSB +: 2] = nx.end_evt;
        nx.irq_status = (st.irq_status & ~irq_clr) | irq_set;
        nx.irq = |(nx.irq_status & nx.irq_mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            st <= '0;
            st.rsp.waitrequest <= 1'b1;
            st.irq_status <= DECT_RST_IRQ;
            st.irq_mask <= DECT_RST_IRQ;
            st.run[0].status <= DECT_ST_IDLE;
            st.run[1].status <= DECT_ST_IDLE;
        end else begin
            st <= nx;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign avs_out = st.rsp;
    assign counter_start_out = st.start_evt;
    assign counter_end_out = st.end_evt;
    assign irq_out = st.irq;

endmodule : dect_top

// >>> dect_partner.sv
`timescale 1ns/1ps
module dect_partner (
    // Clock
    input wire logic mclk_in,
    // Camera signals: user 3:0, logic block 5:4, exposure 6/7, wait 8, lines 12:9
    output logic [12:0] sig_out
);
    // ==========
    // Levels hold between calls; the bench steers them
    initial sig_out = 13'h0000;

    task automatic set_level(input int idx, input logic val);
        @(posedge mclk_in);
        sig_out[idx] <= val;
    endtask : set_level

    // Opposite level for len cycles, then settle time for synchronisers
    task automatic pulse(input int idx, input int len);
        @(posedge mclk_in);
        sig_out[idx] <= ~sig_out[idx];
        repeat (len) @(posedge mclk_in);
        sig_out[idx] <= ~sig_out[idx];
        repeat (4) @(posedge mclk_in);
    endtask : pulse
endmodule : dect_partner

// >>> dect_checker.sv
`timescale 1ns/1ps
module dect_checker (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Bus
    input wire dect_pkg::dect_avs_req_t avs_in,
    input wire dect_pkg::dect_avs_rsp_t avs_out,
    // Events
    input wire logic [1:0] counter_start_out,
    input wire logic [1:0] counter_end_out,
    input wire logic irq_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);
    logic req;
    assign req = avs_in.read | avs_in.write;

    // ==========
    // Bus answers
    bus_answer_a: assert property (req && avs_out.waitrequest |=> !avs_out.waitrequest)
        else $error("bus request not answered next cycle");
    bus_single_a: assert property (!avs_out.waitrequest |=> avs_out.waitrequest)
        else $error("waitrequest low for more than one cycle");
    bus_quiet_a: assert property (!req && avs_out.waitrequest |=> avs_out.waitrequest)
        else $error("answer without request");

    // ==========
    // Event pulses
    start_pulse0_a: assert property (counter_start_out[0] |=> !counter_start_out[0])
        else $error("counter 0 start pulse too long");
    start_pulse1_a: assert property (counter_start_out[1] |-> ##1 !counter_start_out[1])
        else $error("counter 1 start pulse too long");
    end_pulse0_a: assert property ($rose(counter_end_out[0]) |=> !counter_end_out[0])
        else $error("counter 0 end pulse too long");
    end_pulse1_a: assert property (counter_end_out[1] |=> $fell(counter_end_out[1]))
        else $error("counter 1 end pulse too long");

    // ==========
    // Interrupt only moves with an event or a bus write
    irq_cause_a: assert property ($rose(irq_out) |-> (|counter_start_out) || (|counter_end_out) ||
        $past(avs_in.write && !avs_out.waitrequest)) else $error("interrupt rose without cause");
    irq_drop_a: assert property ($fell(irq_out) |-> $past(avs_in.write && !avs_out.waitrequest))
        else $error("interrupt fell without write");
endmodule : dect_checker

bind dect_top dect_checker i_checker (.mclk_in(mclk_in), .rst_in(rst_in), .avs_in(avs_in), .avs_out(avs_out),
    .counter_start_out(counter_start_out), .counter_end_out(counter_end_out), .irq_out(irq_out));

// >>> tb_dual_event_counter_timer.sv
`timescale 1ns/1ps
module tb_dual_event_counter_timer;
    import dect_pkg::*;
    logic mclk_in;
    logic rst_in;
    dect_avs_req_t avs_in;
    dect_avs_rsp_t avs_out;
    logic [12:0] cam;
    logic [1:0] counter_start_out;
    logic [1:0] counter_end_out;
    logic irq_out;
    logic [31:0] rd;
    int failures;
    int n_compared;
    wire [3:0] evts = {counter_end_out, counter_start_out};

    dect_top i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .avs_in(avs_in), .avs_out(avs_out), .line_in(cam[12:9]),
        .user_output_in(cam[3:0]), .logic_block_in(cam[5:4]), .exposure_start_in(cam[6]),
        .exposure_end_in(cam[7]), .frame_trigger_wait_in(cam[8]), .counter_start_out(counter_start_out),
        .counter_end_out(counter_end_out), .irq_out(irq_out));
    dect_partner i_partner (.mclk_in(mclk_in), .sig_out(cam));

    // ==========
    // Shared tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr_en, input logic [5:0] addr, input logic [31:0] data);
        @(posedge mclk_in);
        avs_in <= '{read: !wr_en, write: wr_en, address: addr, writedata: data};
        do @(posedge mclk_in); while (avs_out.waitrequest !== 1'b0);
        rd = avs_out.readdata;
        avs_in <= '0;
    endtask : bus

    task automatic wr(input logic [5:0] addr, input logic [31:0] data);
        bus(1'b1, addr, data);
    endtask : wr

    task automatic rd_chk(input string name, input logic [5:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0000_0000);
        check(name, rd, exp);
    endtask : rd_chk

    task automatic wait_evt(input int idx, input int lim);
        int i;
        i = 0;
        do begin
            @(negedge mclk_in);
            i++;
        end while (evts[idx] !== 1'b1 && i < lim);
    endtask : wait_evt

    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // ==========
    // Scenarios
    task automatic test_regs();
        rd_chk("pick", DECT_OFS_PICK, 32'h0000_0000);
        rd_chk("state", DECT_OFS_STATE, 32'h0000_0000);
        wr(6'h3C, 32'hFFFF_FFFF);
        rd_chk("unmapped", 6'h3C, 32'h0000_0000);
        wr(DECT_OFS_LIVE, 32'h0000_00AA);
        rd_chk("live_ro", DECT_OFS_LIVE, 32'h0000_0000);
        wr(DECT_OFS_DELAY, 32'h0000_0005);
        wr(DECT_OFS_PICK, 32'h0000_0001);
        wr(DECT_OFS_DELAY, 32'h0000_0007);
        wr(DECT_OFS_START_SRC, 32'h0000_0002);
        wr(DECT_OFS_CLR_SRC, 32'h0000_0003);
        rd_chk("start_off", DECT_OFS_START_SRC, 32'h0000_0000);
        rd_chk("delay1", DECT_OFS_DELAY, 32'h0000_0007);
        wr(DECT_OFS_CLR_SRC, 32'h0000_0000);
        wr(DECT_OFS_PICK, 32'h0000_0000);
        rd_chk("delay0", DECT_OFS_DELAY, 32'h0000_0005);
        wr(DECT_OFS_CAPTURED, 32'h0000_1234);
        rd_chk("captured_rw", DECT_OFS_CAPTURED, 32'h0000_1234);
        wr(DECT_OFS_DELAY, 32'h0000_0000);
        $display("test_regs done");
    endtask : test_regs

    // Idle level per mode, then a 3-cycle excursion on user output 0
    task automatic test_modes();
        logic [4:0] idle = 5'h05;
        int cnt[5] = '{3, 3, 1, 1, 2};
        for (int m = 0; m < 5; m++) begin
            wr(DECT_OFS_INC_SRC, 32'h0000_0000);
            i_partner.set_level(0, idle[m]);
            wr(DECT_OFS_INC_MODE, 32'(m));
            wr(DECT_OFS_INC_SRC, 32'(DECT_SRC_USER0));
            i_partner.pulse(0, 3);
            rd_chk("mode_count", DECT_OFS_LIVE, 32'(cnt[m]));
        end
        $display("test_modes done");
    endtask : test_modes

    task automatic test_tick();
        wr(DECT_OFS_INC_SRC, 32'h0000_0000);
        wr(DECT_OFS_DELAY, 32'h0000_0002);
        wr(DECT_OFS_DURATION, 32'h0000_0003);
        wr(DECT_OFS_IRQ_MASK, 32'h0000_0004);
        rd_chk("mask", DECT_OFS_IRQ_MASK, 32'h0000_0004);
        wr(DECT_OFS_INC_SRC, 32'(DECT_SRC_TICK));
        wait_evt(0, 400);
        check("start0", evts[0], 32'h0000_0001);
        check("irq_masked", irq_out, 32'h0000_0000);
        wait_evt(2, 300);
        check("end0", evts[2], 32'h0000_0001);
        check("irq_set", irq_out, 32'h0000_0001);
        rd_chk("live3", DECT_OFS_LIVE, 32'h0000_0003);
        rd_chk("done0", DECT_OFS_STATE, 32'(DECT_ST_COMPLETED));
        rd_chk("irq_st", DECT_OFS_IRQ_STATUS, 32'h0000_0005);
        wr(DECT_OFS_IRQ_STATUS, 32'h0000_0005);
        rd_chk("irq_clr", DECT_OFS_IRQ_STATUS, 32'h0000_0000);
        check("irq_low", irq_out, 32'h0000_0000);
        $display("test_tick done");
    endtask : test_tick

    // Counter 1: armed by line 0 edge, counts exposure starts, cleared by logic block 0
    task automatic test_start_clear();
        // Counter 0 goes idle, then counts end pulses of counter 1
        wr(DECT_OFS_INC_SRC, 32'h0000_0000);
        wr(DECT_OFS_INC_SRC, 32'(DECT_SRC_C1_END));
        wr(DECT_OFS_PICK, 32'h0000_0001);
        wr(DECT_OFS_DELAY, 32'h0000_0002);
        wr(DECT_OFS_DURATION, 32'h0000_0004);
        wr(DECT_OFS_IRQ_MASK, 32'h0000_000F);
        wr(DECT_OFS_START_MODE, 32'(DECT_ACT_RISING));
        wr(DECT_OFS_START_SRC, 32'(DECT_SRC_LINE0));
        wr(DECT_OFS_INC_SRC, 32'(DECT_SRC_EXP_START));
        rd_chk("armed", DECT_OFS_STATE, 32'(DECT_ST_WAIT));
        i_partner.pulse(6, 1);
        rd_chk("no_count", DECT_OFS_LIVE, 32'h0000_0000);
        i_partner.pulse(9, 1);
        rd_chk("started", DECT_OFS_STATE, 32'(DECT_ST_ACTIVE));
        i_partner.pulse(6, 4);
        rd_chk("count4", DECT_OFS_LIVE, 32'h0000_0004);
        rd_chk("done1", DECT_OFS_STATE, 32'(DECT_ST_COMPLETED));
        wr(DECT_OFS_CLR_MODE, 32'(DECT_ACT_LEVEL_HIGH));
        wr(DECT_OFS_CLR_SRC, 32'(DECT_SRC_LB0));
        rd_chk("start_off1", DECT_OFS_START_SRC, 32'h0000_0000);
        i_partner.pulse(4, 1);
        rd_chk("captured", DECT_OFS_CAPTURED, 32'h0000_0004);
        rd_chk("cleared", DECT_OFS_LIVE, 32'h0000_0000);
        rd_chk("rearmed", DECT_OFS_STATE, 32'(DECT_ST_ACTIVE));
        rd_chk("irq_st1", DECT_OFS_IRQ_STATUS, 32'h0000_000A);
        check("irq_on1", irq_out, 32'h0000_0001);
        wr(DECT_OFS_PICK, 32'h0000_0000);
        rd_chk("chained", DECT_OFS_LIVE, 32'h0000_0001);
        $display("test_start_clear done");
    endtask : test_start_clear

    // ==========
    // Clock, sequence, watchdog
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    initial begin
        failures = 0;
        n_compared = 0;
        rst_in = 1'b1;
        avs_in = '0;
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        test_regs();
        test_modes();
        test_tick();
        test_start_clear();
        report_and_stop();
    end

    // Whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge mclk_in);
        failures++;
        report_and_stop();
    end
endmodule : tb_dual_event_counter_timer
